// ### rxls_status.sv
// receive latched event status registers with axi4-lite slave
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rxls_status #(
  parameter int SEC_T1_BITS = 1544000,
  parameter int SEC_E1_BITS = 2048000,
  parameter int SHORT_T1_BITS = 64848,
  parameter int SHORT_E1_BITS = 128000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rxls_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rxls_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_recovered_clock,
  input wire logic rx_line_data,
  input wire logic t1_fbit_strobe,
  input wire logic t1_fbit_error,
  input wire logic b8zs_codeword,
  input wire logic loop_up_code_seen,
  input wire logic e1_fas_strobe,
  input wire logic e1_fas_error,
  input wire logic e1_cas_strobe,
  input wire logic e1_cas_error,
  input wire logic e1_crc_strobe,
  input wire logic e1_crc_error,
  input wire logic e1_crc4_boundary,
  input wire logic e1_ts16_strobe,
  input wire logic e1_ts16_frame0,
  input wire logic [7:0] e1_ts16_data,
  input wire logic link_id_signal,
  input wire logic es_frame_deleted,
  input wire logic es_frame_repeated,
  input wire logic [31:0] signaling_changed
);
  import rxls_pkg::*;

  typedef struct packed {
    logic rc_s1, rc_s2, rc_prev, rd_s1, rd_s2;
    logic [4:0] zrun;
    logic [5:0] fhist;
    logic [9:0] crc_cnt, crc_err;
    logic cas_prev;
    logic [1:0] fas_run;
    logic [3:0] ts_fcnt;
    logic [7:0] ts_zeros;
    logic ts_ones, ts_started, dma_prev, dma;
    logic [11:0] free_cnt;
    logic [8:0] align_cnt;
    logic [15:0] shreg;
    logic loop_down_code_seen, spare_code_match, lup_prev, link_prev, loc;
    logic [3:0] ldn_miss, lsp_miss;
    logic [7:0] loc_cnt;
    logic [21:0] sec_cnt, tmr_cnt;
    logic [3:0] ctl;
    logic [7:0] ldn_code, sp_code;
    logic [31:0] sce;
    logic [7:0] t1_ls2, e1_ls2, t1_ls3, e1_ls3, ls4;
    logic awready, wready, have_aw, have_w, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } rxls_state_t;

  rxls_state_t s_q, s_d;
  logic bit_edge, lbit, e1, wr_go, mapped;
  logic [7:0] set2t, set2e, set3t, set3e, set4, clr;
  logic [9:0] widx, ridx;
  logic [21:0] sec_last, tmr_last;
  logic [7:0] loc_lim;

  always_comb
  begin
    s_d = s_q;
    e1 = s_q.ctl[CTL_E1];
    set2t = '0;
    set2e = '0;
    set3t = '0;
    set3e = '0;
    set4 = '0;
    clr = '0;
    mapped = 1'b0;
    widx = s_q.aw_addr[ADDR_W-1:2];
    ridx = s_axi_araddr[ADDR_W-1:2];
    sec_last = e1 ? 22'(SEC_E1_BITS - 1) : 22'(SEC_T1_BITS - 1);
    tmr_last = !s_q.ctl[CTL_SHORT] ? sec_last
      : (e1 ? 22'(SHORT_E1_BITS - 1) : 22'(SHORT_T1_BITS - 1));
    loc_lim = e1 ? LOC_E1_CYC : LOC_T1_CYC;
    // link pins through two flops, rising edge of the recovered clock
    s_d.rc_s1 = rx_recovered_clock;
    s_d.rc_s2 = s_q.rc_s1;
    s_d.rd_s1 = rx_line_data;
    s_d.rd_s2 = s_q.rd_s1;
    s_d.rc_prev = s_q.rc_s2;
    bit_edge = s_q.rc_s2 && !s_q.rc_prev;
    lbit = s_q.rd_s2;
    // loss of receive clock
    if (s_q.rc_s2 != s_q.rc_prev)
    begin
      s_d.loc_cnt = '0;
      s_d.loc = 1'b0;
    end
    else if (s_q.loc_cnt >= loc_lim)
      s_d.loc = 1'b1;
    else
      s_d.loc_cnt = s_q.loc_cnt + 8'd1;
    if (s_d.loc && !s_q.loc)
    begin
      set3t[B_LOCD] = 1'b1;
      set3e[B_LOCD] = 1'b1;
    end
    if (!s_d.loc && s_q.loc)
    begin
      set3t[B_LOCC] = 1'b1;
      set3e[B_LOCC] = 1'b1;
    end
    if (bit_edge)
    begin
      // zero runs
      if (lbit)
        s_d.zrun = '0;
      else if (s_q.zrun != ZERO16)
        s_d.zrun = s_q.zrun + 5'd1;
      if (!e1 && s_d.zrun == ZERO8 && s_q.zrun != ZERO8)
        set2t[B_8ZD] = 1'b1;
      if (!e1 && s_d.zrun == ZERO16 && s_q.zrun != ZERO16)
        set2t[B_SIXTEEN_ZERO_EVENT] = 1'b1;
      // code match: last sixteen bits hold the code twice
      s_d.shreg = {s_q.shreg[14:0], lbit};
      if (s_d.shreg == {s_q.ldn_code, s_q.ldn_code})
      begin
        s_d.loop_down_code_seen = 1'b1;
        s_d.ldn_miss = '0;
      end
      else if (s_q.ldn_miss == CODE_MISS)
        s_d.loop_down_code_seen = 1'b0;
      else
        s_d.ldn_miss = s_q.ldn_miss + 4'd1;
      if (s_d.shreg == {s_q.sp_code, s_q.sp_code})
      begin
        s_d.spare_code_match = 1'b1;
        s_d.lsp_miss = '0;
      end
      else if (s_q.lsp_miss == CODE_MISS)
        s_d.spare_code_match = 1'b0;
      else
        s_d.lsp_miss = s_q.lsp_miss + 4'd1;
      // free-running bit counters
      s_d.free_cnt = s_q.free_cnt + 12'd1;
      s_d.align_cnt = s_q.align_cnt + 9'd1;
      if (e1 && s_q.align_cnt == ALIGN_LAST)
        set2e[B_RAF] = 1'b1;
      if (e1 && !s_q.ctl[CTL_CRC4] && s_q.free_cnt == FREE_MF_LAST)
        set2e[B_CRC4_MULTIFRAME_EVENT] = 1'b1;
      s_d.sec_cnt = (s_q.sec_cnt >= sec_last) ? '0 : s_q.sec_cnt + 22'd1;
      if (s_q.sec_cnt >= sec_last)
        set4[B_SEC] = 1'b1;
      s_d.tmr_cnt = (s_q.tmr_cnt >= tmr_last) ? '0 : s_q.tmr_cnt + 22'd1;
      if (s_q.tmr_cnt >= tmr_last)
        set4[B_TMR] = 1'b1;
    end
    if (s_q.ctl[CTL_MANUAL])
    begin
      set4[B_TMR] = 1'b1;
      s_d.ctl[CTL_MANUAL] = 1'b0;
    end
    // t1 framing
    if (!e1 && t1_fbit_strobe)
    begin
      s_d.fhist = {s_q.fhist[4:0], t1_fbit_error};
      if (t1_fbit_error)
        set2t[B_FBE] = 1'b1;
      if ($countones(s_d.fhist) >= SEF_ERRS)
        set2t[B_SEVERE_FRAMING_ERROR_EVENT] = 1'b1;
    end
    if (!e1 && b8zs_codeword)
      set2t[B_B8ZS] = 1'b1;
    // t1 loop code edges
    s_d.lup_prev = loop_up_code_seen;
    if (!e1)
    begin
      set3t[B_LOOP_UP_CODE_DETECT] = loop_up_code_seen && !s_q.lup_prev;
      set3t[B_LOOP_UP_CODE_CLEAR] = !loop_up_code_seen && s_q.lup_prev;
      set3t[B_LOOP_DOWN_CODE_DETECT] = s_d.loop_down_code_seen && !s_q.loop_down_code_seen;
      set3t[B_LOOP_DOWN_CODE_CLEAR] = !s_d.loop_down_code_seen && s_q.loop_down_code_seen;
      set3t[B_SPD] = s_d.spare_code_match && !s_q.spare_code_match;
      set3t[B_SPC] = !s_d.spare_code_match && s_q.spare_code_match;
    end
    // e1 resync criteria
    if (e1 && e1_crc_strobe)
    begin
      s_d.crc_cnt = (s_q.crc_cnt == CRC_WIN - 10'd1) ? '0 : s_q.crc_cnt + 10'd1;
      s_d.crc_err = (s_q.crc_cnt == CRC_WIN - 10'd1) ? '0
        : s_q.crc_err + 10'(e1_crc_error);
      if (s_q.crc_err + 10'(e1_crc_error) >= CRC_LIM)
        set2e[B_CRC_RESYNC_CRITERIA_EVENT] = 1'b1;
    end
    if (e1 && e1_cas_strobe)
    begin
      s_d.cas_prev = e1_cas_error;
      if (e1_cas_error && s_q.cas_prev)
        set2e[B_CAS_RESYNC_CRITERIA_EVENT] = 1'b1;
    end
    if (e1 && e1_fas_strobe)
    begin
      s_d.fas_run = !e1_fas_error ? '0
        : (s_q.fas_run == FAS_RUN ? FAS_RUN : s_q.fas_run + 2'd1);
      if (s_d.fas_run == FAS_RUN)
        set2e[B_FRAME_ALIGN_RESYNC_CRITERIA_EVENT] = 1'b1;
    end
    if (e1 && e1_crc4_boundary && s_q.ctl[CTL_CRC4])
      set2e[B_CRC4_MULTIFRAME_EVENT] = 1'b1;
    // timeslot 16 checks
    if (e1 && e1_ts16_strobe)
    begin
      s_d.ts_fcnt = s_q.ts_fcnt + 4'd1;
      s_d.ts_zeros = s_q.ts_zeros + 8'(8 - $countones(e1_ts16_data));
      if (s_q.ts_fcnt == TS16_LAST)
      begin
        // judge the window total before restarting the count
        if (s_d.ts_zeros < TS16_MIN_ZEROS)
          set2e[B_SIGNALING_ALL_ONES_EVENT] = 1'b1;
        s_d.ts_zeros = '0;
      end
      if (e1_ts16_frame0)
      begin
        if (s_q.ts_started && !s_q.ts_ones)
          set2e[B_SIGNALING_ALL_ZEROS_EVENT] = 1'b1;
        s_d.ts_started = 1'b1;
        s_d.ts_ones = |e1_ts16_data;
        s_d.dma_prev = e1_ts16_data[DMA_BIT];
        s_d.dma = e1_ts16_data[DMA_BIT] && s_q.dma_prev;
      end
      else
        s_d.ts_ones = s_q.ts_ones || (|e1_ts16_data);
    end
    s_d.link_prev = link_id_signal;
    if (e1)
    begin
      set3e[B_DMAD] = s_d.dma && !s_q.dma;
      set3e[B_DMAC] = !s_d.dma && s_q.dma;
      set3e[B_LNKD] = link_id_signal && !s_q.link_prev;
      set3e[B_LNKC] = !link_id_signal && s_q.link_prev;
    end
    // elastic store and signaling
    set4[B_ESF] = es_frame_deleted;
    set4[B_ESE] = es_frame_repeated;
    set4[B_SLIP] = es_frame_deleted || es_frame_repeated;
    set4[B_COS] = |(signaling_changed & s_q.sce);
    // axi write channel
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.have_aw = 1'b1;
      s_d.awready = 1'b0;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.have_w = 1'b1;
      s_d.wready = 1'b0;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    wr_go = s_q.have_aw && s_q.have_w && !s_q.bvalid;
    if (wr_go)
    begin
      mapped = 1'b1;
      if (s_q.wstrb[0])
        clr = s_q.wdata[7:0];
      unique case (widx)
        IDX_CTL:
          if (s_q.wstrb[0])
            s_d.ctl = s_q.wdata[3:0];
        IDX_LDN:
          if (s_q.wstrb[0])
            s_d.ldn_code = s_q.wdata[7:0];
        IDX_SPC:
          if (s_q.wstrb[0])
            s_d.sp_code = s_q.wdata[7:0];
        IDX_SCE:
          for (int i = 0; i < 4; i++)
            if (s_q.wstrb[i])
              s_d.sce[i*8 +: 8] = s_q.wdata[i*8 +: 8];
        IDX_LS2, IDX_LS3, IDX_LS4, IDX_LIVE:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
      s_d.have_aw = 1'b0;
      s_d.have_w = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    // latched flags: write one clears, a new event wins
    s_d.t1_ls2 = (s_q.t1_ls2 & ~((wr_go && !e1 && widx == IDX_LS2) ? clr : '0))
      | set2t;
    s_d.e1_ls2 = (s_q.e1_ls2 & ~((wr_go && e1 && widx == IDX_LS2) ? clr : '0))
      | set2e;
    s_d.t1_ls3 = (s_q.t1_ls3 & ~((wr_go && !e1 && widx == IDX_LS3) ? clr : '0))
      | set3t;
    s_d.e1_ls3 = (s_q.e1_ls3 & ~((wr_go && e1 && widx == IDX_LS3) ? clr : '0))
      | set3e;
    s_d.ls4 = (s_q.ls4 & ~((wr_go && widx == IDX_LS4) ? clr : '0)) | set4;
    // axi read channel
    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      unique case (ridx)
        IDX_LS2: s_d.rdata[7:0] = e1 ? s_q.e1_ls2 : s_q.t1_ls2;
        IDX_LS3: s_d.rdata[7:0] = e1 ? s_q.e1_ls3 : s_q.t1_ls3;
        IDX_LS4: s_d.rdata[7:0] = s_q.ls4;
        IDX_CTL: s_d.rdata[3:0] = s_q.ctl;
        IDX_LDN: s_d.rdata[7:0] = s_q.ldn_code;
        IDX_SPC: s_d.rdata[7:0] = s_q.sp_code;
        IDX_SCE: s_d.rdata = s_q.sce;
        IDX_LIVE: s_d.rdata[5:0] = {s_q.dma, s_q.link_prev, s_q.lup_prev, s_q.spare_code_match,
          s_q.loop_down_code_seen, s_q.loc};
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.ctl <= CTL_RESET;
      s_q.t1_ls2 <= LS_RESET;
      s_q.e1_ls2 <= LS_RESET;
      s_q.t1_ls3 <= LS_RESET;
      s_q.e1_ls3 <= LS_RESET;
      s_q.ls4 <= LS_RESET;
    end
    else
      s_q <= s_d;
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_zero8;
    !e1 && bit_edge && !lbit && s_q.zrun == ZERO8 - 5'd1 |=> s_q.t1_ls2[B_8ZD];
  endproperty
  a_zero8: assert property (p_zero8) else $error("eight-zero flag missed");

  property p_zero16;
    !e1 && bit_edge && !lbit && s_q.zrun == ZERO16 - 5'd1 |=> s_q.t1_ls2[B_SIXTEEN_ZERO_EVENT];
  endproperty
  a_zero16: assert property (p_zero16) else $error("sixteen-zero flag missed");

  property p_fbe;
    !e1 && t1_fbit_strobe && t1_fbit_error |=> s_q.t1_ls2[B_FBE];
  endproperty
  a_fbe: assert property (p_fbe) else $error("frame bit error not latched");

  property p_b8zs;
    !e1 && b8zs_codeword |=> s_q.t1_ls2[B_B8ZS];
  endproperty
  a_b8zs: assert property (p_b8zs) else $error("codeword flag not latched");

  sequence s_fas_bad;
    e1 && e1_fas_strobe && e1_fas_error;
  endsequence
  property p_fas3;
    s_q.fas_run == FAS_RUN - 2'd1 ##0 s_fas_bad |=> s_q.e1_ls2[B_FRAME_ALIGN_RESYNC_CRITERIA_EVENT];
  endproperty
  a_fas3: assert property (p_fas3) else $error("frame align resync missed");

  property p_loc;
    $stable(s_q.rc_s2) [*8] ##0 s_q.loc_cnt >= loc_lim |=> s_q.loc;
  endproperty
  a_loc: assert property (p_loc) else $error("clock loss not declared");

  property p_locd;
    $rose(s_q.loc) |-> s_q.t1_ls3[B_LOCD] && s_q.e1_ls3[B_LOCD];
  endproperty
  a_locd: assert property (p_locd) else $error("clock loss onset not latched");

  property p_slip;
    (es_frame_deleted || es_frame_repeated) |=> s_q.ls4[B_SLIP];
  endproperty
  a_slip: assert property (p_slip) else $error("slip flag not latched");

  property p_hold;
    s_q.ls4[B_SEC] && !(wr_go && widx == IDX_LS4 && clr[B_SEC]) |=> s_q.ls4[B_SEC];
  endproperty
  a_hold: assert property (p_hold) else $error("latched flag dropped");

  property p_cos;
    |(signaling_changed & s_q.sce) |=> s_q.ls4[B_COS];
  endproperty
  a_cos: assert property (p_cos) else $error("change of state not latched");
endmodule
`default_nettype wire

// ### rxls_pkg.sv
// constants for the receive latched event status block
package rxls_pkg;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_LS2 = 10'h091;
  localparam logic [9:0] IDX_LS3 = 10'h092;
  localparam logic [9:0] IDX_LS4 = 10'h093;
  localparam logic [9:0] IDX_CTL = 10'h0a0;
  localparam logic [9:0] IDX_LDN = 10'h0a1;
  localparam logic [9:0] IDX_SPC = 10'h0a2;
  localparam logic [9:0] IDX_SCE = 10'h0a3;
  localparam logic [9:0] IDX_LIVE = 10'h0a4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register fields
  localparam int CTL_E1 = 0;
  localparam int CTL_SHORT = 1;
  localparam int CTL_CRC4 = 2;
  localparam int CTL_MANUAL = 3;
  localparam logic [3:0] CTL_RESET = 4'h0;
  localparam logic [7:0] LS_RESET = 8'h00;
  // t1 status 2
  localparam int B_8ZD = 4;
  localparam int B_SIXTEEN_ZERO_EVENT = 3;
  localparam int B_SEVERE_FRAMING_ERROR_EVENT = 2;
  localparam int B_B8ZS = 1;
  localparam int B_FBE = 0;
  // e1 status 2
  localparam int B_CRC_RESYNC_CRITERIA_EVENT = 6;
  localparam int B_CAS_RESYNC_CRITERIA_EVENT = 5;
  localparam int B_FRAME_ALIGN_RESYNC_CRITERIA_EVENT = 4;
  localparam int B_SIGNALING_ALL_ONES_EVENT = 3;
  localparam int B_SIGNALING_ALL_ZEROS_EVENT = 2;
  localparam int B_CRC4_MULTIFRAME_EVENT = 1;
  localparam int B_RAF = 0;
  // status 3, both modes
  localparam int B_LOCC = 7;
  localparam int B_SPC = 6;
  localparam int B_LOOP_DOWN_CODE_CLEAR = 5;
  localparam int B_LOOP_UP_CODE_CLEAR = 4;
  localparam int B_LOCD = 3;
  localparam int B_SPD = 2;
  localparam int B_LOOP_DOWN_CODE_DETECT = 1;
  localparam int B_LOOP_UP_CODE_DETECT = 0;
  localparam int B_LNKC = 5;
  localparam int B_DMAC = 4;
  localparam int B_LNKD = 1;
  localparam int B_DMAD = 0;
  // status 4
  localparam int B_ESF = 7;
  localparam int B_ESE = 6;
  localparam int B_SLIP = 5;
  localparam int B_COS = 3;
  localparam int B_SEC = 2;
  localparam int B_TMR = 1;
  // line event figures
  localparam logic [4:0] ZERO8 = 5'd8;
  localparam logic [4:0] ZERO16 = 5'd16;
  localparam int SEF_ERRS = 2;
  localparam logic [9:0] CRC_WIN = 10'd1000;
  localparam logic [9:0] CRC_LIM = 10'd915;
  localparam logic [1:0] FAS_RUN = 2'd3;
  localparam logic [3:0] TS16_LAST = 4'd15;
  localparam logic [7:0] TS16_MIN_ZEROS = 8'd3;
  localparam int DMA_BIT = 2;
  localparam logic [11:0] FREE_MF_LAST = 12'd4095;
  localparam logic [8:0] ALIGN_LAST = 9'd511;
  localparam logic [3:0] CODE_MISS = 4'd8;
  // loss of receive clock: one channel time, rounded up to cycles
  localparam int CLK_NS = 50;
  localparam int CHAN_T1_NS = 5182;
  localparam int CHAN_E1_NS = 3907;
  localparam logic [7:0] LOC_T1_CYC = 8'((CHAN_T1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] LOC_E1_CYC = 8'((CHAN_E1_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ### rxls_link_model.sv
// link-side model: recovered receive clock and received line data
`timescale 1ns/100ps
`default_nettype none
module rxls_link_model (
  output logic rx_recovered_clock,
  output logic rx_line_data
);
  initial
  begin
    rx_recovered_clock = 1'b0;
    rx_line_data = 1'b1;
  end
  // clock runs only within a burst; afterwards the line shows the inverse of the last bit
  task automatic send(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++)
    begin
      rx_line_data = b[7 - k % 8];
      #113 rx_recovered_clock = 1'b1;
      #200 rx_recovered_clock = 1'b0;
      #87;
    end
    rx_line_data = ~rx_line_data;
  endtask
endmodule
`default_nettype wire

// ### rx_framer_latched_event_status_test.sv
// self-checking bench for the receive latched event status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module rx_framer_latched_event_status_test;
  import rxls_pkg::*;
  int num_errors = 0;
  int comparisons = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] signaling_changed = 32'h0;
  logic [7:0] e1_ts16_data = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, t1_fbit_strobe = 1'b0;
  logic t1_fbit_error = 1'b0, b8zs_codeword = 1'b0, loop_up_code_seen = 1'b0;
  logic e1_fas_strobe = 1'b0, e1_fas_error = 1'b0, e1_cas_strobe = 1'b0;
  logic e1_cas_error = 1'b0, e1_crc_strobe = 1'b0, e1_crc_error = 1'b0;
  logic e1_crc4_boundary = 1'b0, e1_ts16_strobe = 1'b0, e1_ts16_frame0 = 1'b0;
  logic link_id_signal = 1'b0, es_frame_deleted = 1'b0, es_frame_repeated = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [31:0] s_axi_rdata, rd_d;
  logic rx_recovered_clock, rx_line_data;

  always #25 aclk = ~aclk;

  rxls_link_model lnk (.rx_recovered_clock, .rx_line_data);

  rxls_status #(.SEC_T1_BITS(40), .SEC_E1_BITS(50), .SHORT_T1_BITS(10), .SHORT_E1_BITS(12)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_recovered_clock, .rx_line_data,
    .t1_fbit_strobe, .t1_fbit_error, .b8zs_codeword, .loop_up_code_seen, .e1_fas_strobe,
    .e1_fas_error, .e1_cas_strobe, .e1_cas_error, .e1_crc_strobe, .e1_crc_error,
    .e1_crc4_boundary, .e1_ts16_strobe, .e1_ts16_frame0, .e1_ts16_data, .link_id_signal,
    .es_frame_deleted, .es_frame_repeated, .signaling_changed
  );

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic look(input string nm, input logic [9:0] i, input logic [7:0] m,
    input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    `CHK(nm, e, d[7:0] & m)
  endtask

  // one strobe per call, k picks which one
  task automatic pulse(input int k, input logic e);
    {t1_fbit_strobe, b8zs_codeword, es_frame_deleted, es_frame_repeated, e1_crc4_boundary,
      e1_fas_strobe, e1_cas_strobe, e1_crc_strobe} <= 8'(8'h80 >> k);
    t1_fbit_error <= e;
    e1_fas_error <= e;
    e1_cas_error <= e;
    e1_crc_error <= e;
    tick(1);
    {t1_fbit_strobe, b8zs_codeword, es_frame_deleted, es_frame_repeated, e1_crc4_boundary,
      e1_fas_strobe, e1_cas_strobe, e1_crc_strobe} <= 8'h00;
    tick(1);
  endtask

  // two multiframes with the same timeslot 16 octet
  task automatic mf(input logic [7:0] b);
    for (int k = 0; k < 32; k++)
    begin
      e1_ts16_strobe <= 1'b1;
      e1_ts16_frame0 <= (k % 16 == 0);
      e1_ts16_data <= b;
      tick(1);
      e1_ts16_strobe <= 1'b0;
      tick(1);
    end
  endtask

  task automatic bits(input logic [7:0] b, input int n);
    lnk.send(b, n);
    tick(12);
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #4000000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    tick(20);
    aresetn <= 1'b1;
    tick(1);
    look("ls2_reset", IDX_LS2, 8'hff, LS_RESET);
    look("ls3_reset", IDX_LS3, 8'hff, LS_RESET);
    look("ls4_reset", IDX_LS4, 8'hff, LS_RESET);
    look("ctl_reset", IDX_CTL, 8'h0f, {4'h0, CTL_RESET});
    rd(10'h0ff, rd_d, rd_r);
    `CHK("unmapped", RESP_SLVERR, rd_r)
    wr(10'h0ff, 32'h0);
    `CHK("unmapped_wr", RESP_SLVERR, wr_r)
    bits(8'h01, 8);
    look("zero7", IDX_LS2, 8'h18, 8'h00);
    bits(8'h00, 8);
    look("zero8", IDX_LS2, 8'h18, 8'h10);
    wr(IDX_LS2, 32'hff);
    bits(8'h00, 8);
    bits(8'hff, 8);
    look("zero16", IDX_LS2, 8'h08, 8'h08);
    wr(IDX_LS2, 32'hff);
    look("cleared", IDX_LS2, 8'hff, 8'h00);
    pulse(0, 1'b1);
    repeat (5) pulse(0, 1'b0);
    look("fbe", IDX_LS2, 8'h05, 8'h01);
    wr(IDX_LS2, 32'hff);
    pulse(0, 1'b1);
    pulse(0, 1'b1);
    look("severe_framing_error_event", IDX_LS2, 8'h04, 8'h04);
    pulse(1, 1'b0);
    look("b8zs", IDX_LS2, 8'h02, 8'h02);
    loop_up_code_seen <= 1'b1;
    tick(4);
    look("lup_on", IDX_LS3, 8'h11, 8'h01);
    loop_up_code_seen <= 1'b0;
    tick(4);
    look("lup_off", IDX_LS3, 8'h11, 8'h11);
    for (int j = 0; j < 2; j++)
    begin
      wr(IDX_LDN, j ? 32'h55 : 32'hc3);
      wr(IDX_SPC, j ? 32'hc3 : 32'h55);
      // flush so earlier matches drop before the flags are cleared
      bits(8'hff, 16);
      wr(IDX_LS3, 32'hff);
      bits(8'hc3, 32);
      look("code_on", IDX_LS3, 8'h66, j ? 8'h04 : 8'h02);
      bits(8'hff, 16);
      look("code_off", IDX_LS3, 8'h66, j ? 8'h44 : 8'h22);
    end
    wr(IDX_LS3, 32'hff);
    look("loss_none", IDX_LS3, 8'h88, 8'h00);
    tick(120);
    look("loss_on", IDX_LS3, 8'h88, 8'h08);
    bits(8'hff, 8);
    look("loss_off", IDX_LS3, 8'h88, 8'h88);
    wr(IDX_LS4, 32'hff);
    pulse(2, 1'b0);
    look("es_full", IDX_LS4, 8'he0, 8'ha0);
    wr(IDX_LS4, 32'hff);
    pulse(3, 1'b0);
    look("es_empty", IDX_LS4, 8'he0, 8'h60);
    wr(IDX_SCE, 32'h20);
    signaling_changed <= 32'h10;
    tick(1);
    signaling_changed <= 32'h0;
    look("cos_off", IDX_LS4, 8'h08, 8'h00);
    signaling_changed <= 32'h20;
    tick(1);
    signaling_changed <= 32'h0;
    look("cos_on", IDX_LS4, 8'h08, 8'h08);
    wr(IDX_LS4, 32'hff);
    wr(IDX_CTL, 32'h8);
    look("manual", IDX_LS4, 8'h02, 8'h02);
    wr(IDX_CTL, 32'h5);
    wr(IDX_LS2, 32'hff);
    wr(IDX_LS3, 32'hff);
    pulse(5, 1'b1);
    pulse(5, 1'b1);
    pulse(6, 1'b1);
    look("fas2_cas1", IDX_LS2, 8'h30, 8'h00);
    pulse(5, 1'b1);
    pulse(6, 1'b1);
    look("fas3_cas2", IDX_LS2, 8'h30, 8'h30);
    for (int w = 0; w < 2; w++)
    begin
      for (int i = 0; i < 1000; i++)
        pulse(7, i < 914 + w);
      look("crc", IDX_LS2, 8'h40, w ? 8'h40 : 8'h00);
    end
    mf(8'hff);
    look("ts16_ones", IDX_LS2, 8'h0c, 8'h08);
    look("dma_on", IDX_LS3, 8'h11, 8'h01);
    wr(IDX_LS2, 32'hff);
    mf(8'h00);
    look("ts16_zeros", IDX_LS2, 8'h0c, 8'h04);
    look("dma_off", IDX_LS3, 8'h11, 8'h11);
    link_id_signal <= 1'b1;
    tick(4);
    look("link_on", IDX_LS3, 8'h22, 8'h02);
    link_id_signal <= 1'b0;
    tick(4);
    look("link_off", IDX_LS3, 8'h22, 8'h22);
    pulse(4, 1'b0);
    look("crc_mf", IDX_LS2, 8'h02, 8'h02);
    wr(IDX_LS2, 32'hff);
    wr(IDX_LS4, 32'hff);
    look("no_align", IDX_LS2, 8'h01, 8'h00);
    bits(8'hff, 520);
    look("align", IDX_LS2, 8'h01, 8'h01);
    look("sec_timer", IDX_LS4, 8'h06, 8'h06);
    wr(IDX_CTL, 32'h1);
    wr(IDX_LS2, 32'hff);
    bits(8'hff, 4100);
    look("free_mf", IDX_LS2, 8'h02, 8'h02);
    print_verdict();
  end
endmodule
`default_nettype wire
